// [boot_seq_pkg.sv]
// Constants shared by the boot sequencer and its image buffer.
// Assumes a single system clock and a synchronous active-high reset.
`default_nettype none
package boot_seq_pkg;

    // ========================================================================
    // Register port
    localparam int          REG_ADDR_W     = 3;
    localparam int          REG_DATA_W     = 32;
    localparam logic [2:0]  OFS_PORT_DATA  = 3'h0;
    localparam logic [2:0]  OFS_EDGE_FLAG  = 3'h3;
    localparam logic        RST_PORT_DATA  = 1'b0;
    localparam logic        RST_EDGE_FLAG  = 1'b0;

    // ========================================================================
    // Instruction and branch word layout
    localparam int          WORD_W         = 32;
    localparam int          ALIGN_BITS     = 2;
    localparam int          BR_ZERO_MSB    = 31;
    localparam int          BR_ZERO_LSB    = 22;
    localparam int          BR_OFS_MSB     = 21;
    localparam int          BR_OFS_LSB     = 6;
    localparam int          BR_OP_MSB      = 5;
    localparam int          BR_OP_LSB      = 0;
    localparam logic [5:0]  BR_OPCODE      = 6'h06;
    localparam logic [31:0] RESET_ADDR     = 32'h0000_0000;

    // ========================================================================
    // Image buffer
    localparam int          FIFO_DEPTH     = 16;
    localparam int          FIFO_WIDTH     = 2 * WORD_W;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_ACK, ST_SAFE} hold_state_t;

endpackage
`default_nettype wire

// [fifo_if.sv]
// Valid/ready carrier between the sequencer and its image buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface fifo_if #(
    parameter int WIDTH = 64
);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport buf_mp  (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
    modport user_mp (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// [image_fifo.sv]
// Flip-flop FIFO holding image words on their way to program memory.
// Assumes a synchronous active-high reset and one clock.
`timescale 1ns/100ps
`default_nettype none
module image_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // Buffer ports
    fifo_if.buf_mp    port
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem_reg  [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic             ready_reg, ready_next;
    logic             push;
    logic             pop;

    // ========================================================================
    // Storage
    assign push = port.push_valid & ready_reg;
    assign pop  = port.pop_valid & port.pop_ready;

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            assign mem_next[gi] = (push && wr_ptr_reg == PTR_W'(gi)) ? port.push_data : mem_reg[gi];
            always_ff @(posedge clk_i) begin
                mem_reg[gi] <= mem_next[gi];
            end
        end
    endgenerate

    // ========================================================================
    // Pointers and occupancy
    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
        // Ready is registered so the source sees a flop; it is taken from the next count so no slot is lost.
        ready_next = (count_next != FULL_CNT);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= 1'b1;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
            ready_reg  <= ready_next;
        end
    end

    assign port.push_ready = ready_reg;
    assign port.pop_valid  = (count_reg != '0);
    assign port.pop_data   = mem_reg[rd_ptr_reg];

    // ========================================================================
    // Checks
    AST_FIFO_BOUND: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        count_reg <= FULL_CNT) else $error("Image buffer occupancy out of range.");
    AST_FIFO_FULL_STALL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (count_reg == FULL_CNT) |-> !port.push_ready) else $error("Full buffer still accepts words.");
    COV_FIFO_FULL: cover property (@(posedge clk_i) disable iff (sys_rst_i) count_reg == FULL_CNT);
endmodule
`default_nettype wire

// [external_boot_sequencer.sv]
// Boot-control sequencer: a one-bit parallel port that holds the core,
// captures its halt acknowledge, and buffers image words into program memory.
// Assumes the core pulses halt_ack_i while held and all inputs are synchronous.
`timescale 1ns/100ps
`default_nettype none
module external_boot_sequencer (
    // Clock and reset
    input  wire logic                                clk_i,
    input  wire logic                                sys_rst_i,
    // Register port
    input  wire logic [boot_seq_pkg::REG_ADDR_W-1:0] reg_addr_i,
    input  wire logic                                reg_write_i,
    input  wire logic [boot_seq_pkg::REG_DATA_W-1:0] reg_wdata_i,
    input  wire logic                                reg_read_i,
    output logic      [boot_seq_pkg::REG_DATA_W-1:0] reg_rdata_o,
    // Core handshake
    input  wire logic                                halt_ack_i,
    output logic                                     hold_req_o,
    // Image word stream
    input  wire logic                                img_valid_i,
    input  wire logic [boot_seq_pkg::WORD_W-1:0]     img_addr_i,
    input  wire logic [boot_seq_pkg::WORD_W-1:0]     img_data_i,
    output logic                                     img_ready_o,
    // Program memory write port
    output logic                                     mem_wr_valid_o,
    output logic      [boot_seq_pkg::WORD_W-1:0]     mem_wr_addr_o,
    output logic      [boot_seq_pkg::WORD_W-1:0]     mem_wr_data_o,
    input  wire logic                                mem_wr_ready_i,
    // Status
    output logic                                     align_err_o,
    output logic                                     branch_ok_o
);
    import boot_seq_pkg::*;

    hold_state_t         state_reg, state_next;
    logic                port_data_reg, port_data_next;
    logic                edge_flag_reg, edge_flag_next;
    logic                ack_prev_reg, ack_prev_next;
    logic [REG_DATA_W-1:0] rdata_reg, rdata_next;
    logic                out_valid_reg, out_valid_next;
    logic [WORD_W-1:0]   out_addr_reg, out_addr_next;
    logic [WORD_W-1:0]   out_data_reg, out_data_next;
    logic                align_err_reg, align_err_next;
    logic                branch_ok_reg, branch_ok_next;
    logic                ack_rise;
    logic                wr_port;
    logic                wr_edge;
    logic                take;
    logic                misaligned;
    logic [WORD_W-1:0]   pop_addr;
    logic [WORD_W-1:0]   pop_word;

    fifo_if #(.WIDTH(FIFO_WIDTH)) img_buf ();

    image_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_image_fifo (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .port      (img_buf.buf_mp)
    );

    // ========================================================================
    // Parallel port and hold control
    // The acknowledge is only one cycle wide, so it is caught as an edge rather than sampled.
    assign ack_rise = halt_ack_i & ~ack_prev_reg;
    assign wr_port  = reg_write_i && (reg_addr_i == OFS_PORT_DATA);
    assign wr_edge  = reg_write_i && (reg_addr_i == OFS_EDGE_FLAG);

    always_comb begin
        ack_prev_next  = halt_ack_i;
        port_data_next = wr_port ? reg_wdata_i[0] : port_data_reg;
        // A capture in the same cycle as the clearing write wins, so no acknowledge is lost.
        edge_flag_next = ack_rise ? 1'b1 : (wr_edge ? 1'b0 : edge_flag_reg);
        rdata_next     = rdata_reg;
        if (reg_read_i) begin
            case (reg_addr_i)
                OFS_PORT_DATA: rdata_next = {{(REG_DATA_W-1){1'b0}}, port_data_reg};
                OFS_EDGE_FLAG: rdata_next = {{(REG_DATA_W-1){1'b0}}, edge_flag_reg};
                default:       rdata_next = '0;
            endcase
        end
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (port_data_reg) begin
                    state_next = ST_WAIT_ACK;
                end
            end
            ST_WAIT_ACK: begin
                if (!port_data_reg) begin
                    state_next = ST_IDLE;
                end else if (ack_rise) begin
                    state_next = ST_SAFE;
                end
            end
            ST_SAFE: begin
                if (!port_data_reg) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg     <= ST_IDLE;
            port_data_reg <= RST_PORT_DATA;
            edge_flag_reg <= RST_EDGE_FLAG;
            ack_prev_reg  <= 1'b0;
            rdata_reg     <= '0;
        end else begin
            state_reg     <= state_next;
            port_data_reg <= port_data_next;
            edge_flag_reg <= edge_flag_next;
            ack_prev_reg  <= ack_prev_next;
            rdata_reg     <= rdata_next;
        end
    end

    // ========================================================================
    // Image drain into program memory
    // Words wait in the buffer until the core is known to be held, so the source is stalled, not dropped.
    assign img_buf.push_valid = img_valid_i;
    assign img_buf.push_data  = {img_addr_i, img_data_i};
    // The hold must still be high, so no word slips out in the cycle in which the host releases the core.
    assign img_buf.pop_ready  = (state_reg == ST_SAFE) && port_data_reg && (!out_valid_reg || mem_wr_ready_i);
    assign pop_addr   = img_buf.pop_data[FIFO_WIDTH-1:WORD_W];
    assign pop_word   = img_buf.pop_data[WORD_W-1:0];
    assign take       = img_buf.pop_valid & img_buf.pop_ready;
    assign misaligned = (pop_addr[ALIGN_BITS-1:0] != '0);

    always_comb begin
        out_valid_next = out_valid_reg;
        out_addr_next  = out_addr_reg;
        out_data_next  = out_data_reg;
        align_err_next = align_err_reg;
        branch_ok_next = branch_ok_reg;
        if (take && !misaligned) begin
            out_valid_next = 1'b1;
            out_addr_next  = pop_addr;
            out_data_next  = pop_word;
        end else if (mem_wr_ready_i) begin
            out_valid_next = 1'b0;
        end
        if (take && misaligned) begin
            align_err_next = 1'b1;
        end
        if (take && !misaligned && pop_addr == RESET_ADDR) begin
            branch_ok_next = (pop_word[BR_ZERO_MSB:BR_ZERO_LSB] == '0)
                          && (pop_word[BR_OP_MSB:BR_OP_LSB] == BR_OPCODE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_valid_reg <= 1'b0;
            out_addr_reg  <= '0;
            out_data_reg  <= '0;
            align_err_reg <= 1'b0;
            branch_ok_reg <= 1'b0;
        end else begin
            out_valid_reg <= out_valid_next;
            out_addr_reg  <= out_addr_next;
            out_data_reg  <= out_data_next;
            align_err_reg <= align_err_next;
            branch_ok_reg <= branch_ok_next;
        end
    end

    assign hold_req_o     = port_data_reg;
    assign reg_rdata_o    = rdata_reg;
    assign img_ready_o    = img_buf.push_ready;
    assign mem_wr_valid_o = out_valid_reg;
    assign mem_wr_addr_o  = out_addr_reg;
    assign mem_wr_data_o  = out_data_reg;
    assign align_err_o    = align_err_reg;
    assign branch_ok_o    = branch_ok_reg;

    // ========================================================================
    // Checks
    AST_EDGE_CAPTURE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (halt_ack_i && !ack_prev_reg) |=> edge_flag_reg ##1 (edge_flag_reg || $past(wr_edge)))
        else $error("Rising acknowledge not captured.");
    AST_EDGE_HOLDS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (edge_flag_reg && !wr_edge) |=> edge_flag_reg) else $error("Captured bit lost without a write.");
    AST_EDGE_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (reg_read_i && reg_addr_i == OFS_EDGE_FLAG) |=> (reg_rdata_o == {31'h0, $past(edge_flag_reg)}))
        else $error("Captured bit read back wrongly.");
    AST_RESET_LOW: assert property (@(posedge clk_i)
        sys_rst_i |=> (!hold_req_o && !reg_rdata_o[0] && !edge_flag_reg)) else $error("Outputs not low after reset.");
    AST_HOLD_RELEASE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (reg_write_i && reg_addr_i == OFS_PORT_DATA) |=> (hold_req_o == $past(reg_wdata_i[0])))
        else $error("Hold output did not follow the port write.");
    AST_NO_EARLY_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(mem_wr_valid_o) |-> ($past(state_reg) == ST_SAFE && $past(hold_req_o)))
        else $error("Program memory written before the core was held.");
    AST_SAFE_NEEDS_ACK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_reg == ST_WAIT_ACK && !ack_rise) |=> (state_reg != ST_SAFE))
        else $error("Safe state entered without acknowledge.");
    AST_ALIGNED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mem_wr_valid_o |-> (mem_wr_addr_o[1:0] == 2'h0)) else $error("Misaligned program memory write.");
    AST_BRANCH_FORM: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (mem_wr_valid_o && mem_wr_addr_o == RESET_ADDR && branch_ok_o && $changed(mem_wr_data_o))
        |-> (mem_wr_data_o[5:0] == 6'h06 && mem_wr_data_o[31:22] == 10'h000))
        else $error("Branch flag set for a malformed word.");
    AST_OUT_STABLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (mem_wr_valid_o && !mem_wr_ready_i) |=> (mem_wr_valid_o && $stable(mem_wr_addr_o) && $stable(mem_wr_data_o)))
        else $error("Memory write changed while stalled.");

    COV_HOLD_ACK: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        hold_req_o ##[1:50] edge_flag_reg);
    COV_COPY: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        mem_wr_valid_o && mem_wr_ready_i && branch_ok_o);
    COV_RELEASE: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_reg == ST_SAFE) ##1 (state_reg == ST_IDLE));
endmodule
`default_nettype wire

// [core_model.sv]
// Behavioural model of the held core and of its program memory write port.
// Assumes the sequencer's hold request and memory port share one clock.
`timescale 1ns/100ps
`default_nettype none
module core_model #(
    parameter int DRAIN  = 30,
    parameter int PERIOD = 8
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // Handshake and memory port
    input  wire logic hold_req_i,
    input  wire logic slow_i,
    output var  logic halt_ack_o,
    output var  logic mem_wr_ready_o
);
    // ========================================================================
    // Hold handshake
    int cnt;

    always @(posedge clk_i) begin
        if (sys_rst_i || !hold_req_i) begin
            cnt        <= 0;
            halt_ack_o <= 1'b0;
        end else begin
            cnt        <= cnt + 1;
            halt_ack_o <= (cnt >= DRAIN) && ((cnt - DRAIN) % PERIOD == 0);
        end
    end

    // ========================================================================
    // Memory side
    // A slow memory takes a write only every other cycle, so the drain must stall.
    always @(posedge clk_i) begin
        mem_wr_ready_o <= sys_rst_i ? 1'b0 : (slow_i ? ~mem_wr_ready_o : 1'b1);
    end
endmodule
`default_nettype wire

// [external_boot_sequencer_tb_top.sv]
// Self-checking bench for the boot sequencer with a model of the held core.
// Assumes a core that pulses its halt acknowledge periodically while it is held.
`timescale 1ns/100ps
`default_nettype none
module external_boot_sequencer_tb_top;
    import boot_seq_pkg::*;

    // ========================================================================
    // Signals
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [2:0]  reg_addr_i = 3'h0;
    logic        reg_write_i = 1'b0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_read_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        core_ack;
    logic        tb_ack = 1'b0;
    logic        hold_req_o;
    logic        img_valid_i = 1'b0;
    logic [31:0] img_addr_i = 32'h0;
    logic [31:0] img_data_i = 32'h0;
    logic        img_ready_o;
    logic        mem_wr_valid_o;
    logic [31:0] mem_wr_addr_o;
    logic [31:0] mem_wr_data_o;
    logic        mem_wr_ready_i;
    logic        align_err_o;
    logic        branch_ok_o;
    logic        slow = 1'b1;
    logic [31:0] wa[$];
    logic [31:0] wd[$];
    int          num_errors = 0;
    int          checks = 0;

    always #2 clk_i = ~clk_i;

    external_boot_sequencer u_external_boot_sequencer (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_write_i(reg_write_i),
        .reg_wdata_i(reg_wdata_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
        .halt_ack_i(core_ack | tb_ack), .hold_req_o(hold_req_o), .img_valid_i(img_valid_i),
        .img_addr_i(img_addr_i), .img_data_i(img_data_i), .img_ready_o(img_ready_o),
        .mem_wr_valid_o(mem_wr_valid_o), .mem_wr_addr_o(mem_wr_addr_o), .mem_wr_data_o(mem_wr_data_o),
        .mem_wr_ready_i(mem_wr_ready_i), .align_err_o(align_err_o), .branch_ok_o(branch_ok_o));

    core_model u_core_model (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hold_req_i(hold_req_o), .slow_i(slow),
        .halt_ack_o(core_ack), .mem_wr_ready_o(mem_wr_ready_i));

    // Every write the memory takes is logged for later comparison.
    always @(posedge clk_i) begin
        if (mem_wr_valid_o === 1'b1 && mem_wr_ready_i === 1'b1) begin
            wa.push_back(mem_wr_addr_o);
            wd.push_back(mem_wr_data_o);
        end
    end

    // ========================================================================
    // Helpers
    task automatic end_sim();
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic step();
        @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One idle cycle follows each access so no strobe is set and cleared in one step.
    task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_write_i = 1'b1;
        step();
        reg_write_i = 1'b0;
        step();
    endtask

    task automatic reg_rd(input logic [2:0] a, output logic [31:0] d);
        reg_addr_i = a;
        reg_read_i = 1'b1;
        step();
        reg_read_i = 1'b0;
        d = reg_rdata_o;
        step();
    endtask

    task automatic push(input logic [31:0] a, input logic [31:0] d, output bit took);
        img_valid_i = 1'b1;
        img_addr_i = a;
        img_data_i = d;
        took = 1'b0;
        for (int n = 0; n < 4 && !took; n++) begin
            took = (img_ready_o === 1'b1);
            step();
        end
    endtask

    task automatic wait_wr(input int cnt);
        int n;
        for (n = 0; n < 300 && wa.size() < cnt; n++) step();
        if (wa.size() < cnt) begin
            num_errors++;
            end_sim();
        end
    endtask

    // Clears the flag, raises hold and polls until the core is known to be held.
    task automatic hold_core();
        logic [31:0] d;
        int n;
        reg_wr(OFS_EDGE_FLAG, 32'h5a5a_a5a5);
        reg_wr(OFS_PORT_DATA, 32'h1);
        chk("hold_req_o", 32'h1, {31'h0, hold_req_o});
        reg_rd(OFS_EDGE_FLAG, d);
        chk("flag_early", 32'h0, d);
        chk("early_writes", 32'h0, wa.size());
        d = 32'h0;
        for (n = 0; n < 100 && d !== 32'h1; n++) reg_rd(OFS_EDGE_FLAG, d);
        if (d !== 32'h1) begin
            num_errors++;
            end_sim();
        end
    endtask

    // ========================================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] d;
        chk("hold_rst", 32'h0, {31'h0, hold_req_o});
        reg_rd(OFS_EDGE_FLAG, d);
        chk("flag_rst", {31'h0, RST_EDGE_FLAG}, d);
        reg_wr(3'h5, 32'h1);
        reg_rd(OFS_PORT_DATA, d);
        chk("port_rst", {31'h0, RST_PORT_DATA}, d);
        reg_rd(3'h5, d);
        chk("unmapped", 32'h0, d);
    endtask

    // Image is built whole first; hold is low so nothing may drain yet.
    task automatic t_boot();
        logic [31:0] d;
        bit          took;
        logic [31:0] br;
        br = {10'h0, 16'(32'h100 - RESET_ADDR - 32'h4), BR_OPCODE};
        for (int i = 0; i < 14; i++) begin
            push(32'h100 + 32'(4 * i), 32'hc0de_0000 + 32'(i), took);
        end
        push(32'h202, 32'hdead_beef, took);
        push(RESET_ADDR, br, took);
        push(32'h300, 32'h1, took);
        img_valid_i = 1'b0;
        chk("full_refuse", 32'h0, {31'h0, took});
        tb_ack = 1'b1;
        step();
        tb_ack = 1'b0;
        step();
        reg_rd(OFS_EDGE_FLAG, d);
        chk("flag_edge", 32'h1, d);
        chk("drain_idle", 32'h0, wa.size());
        hold_core();
        wait_wr(15);
        for (int i = 0; i < 14; i++) begin
            chk("wr_addr", 32'h100 + 32'(4 * i), wa[i]);
            chk("wr_data", 32'hc0de_0000 + 32'(i), wd[i]);
        end
        chk("br_addr", RESET_ADDR, wa[14]);
        chk("br_word", br, wd[14]);
        step();
        chk("align_err", 32'h1, {31'h0, align_err_o});
        chk("branch_ok", 32'h1, {31'h0, branch_ok_o});
        reg_wr(OFS_PORT_DATA, 32'h0);
        chk("hold_drop", 32'h0, {31'h0, hold_req_o});
    endtask

    // A word at the reset address with a wrong opcode is not a valid branch.
    task automatic t_bad_branch();
        bit took;
        wa.delete();
        wd.delete();
        slow = 1'b0;
        push(RESET_ADDR, 32'h0000_3f87, took);
        img_valid_i = 1'b0;
        hold_core();
        wait_wr(1);
        step();
        chk("branch_bad", 32'h0, {31'h0, branch_ok_o});
        reg_wr(OFS_PORT_DATA, 32'h0);
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        t_reset();
        t_boot();
        t_bad_branch();
        end_sim();
    end
endmodule
`default_nettype wire
